/* core/emnab_params.svh */
// constants of the external non-multiplexed memory bus controller
`ifndef EMNAB_PARAMS_SVH
`define EMNAB_PARAMS_SVH

// ==========================================================================
// address decode
`define EMNAB_REG_SPACE_BIT  20
`define EMNAB_BANK_BIT_HI    17
`define EMNAB_BANK_BIT_LO    16
`define EMNAB_OFF_STATUS     8'h80
`define EMNAB_OFF_CTRL       5'h00
`define EMNAB_OFF_RDLY       5'h04
`define EMNAB_OFF_RWAIT      5'h08
`define EMNAB_OFF_WDLY       5'h0C
`define EMNAB_OFF_WWAIT      5'h10
`define EMNAB_OFF_BWAIT      5'h14

// ==========================================================================
// bank control fields
`define EMNAB_SYNC_WR_BIT    17
`define EMNAB_BURST_READ_LENGTH_HI       11
`define EMNAB_BURST_READ_LENGTH_LO       10
`define EMNAB_SYNC_RD_BIT    9
`define EMNAB_PAGE_EN_BIT    8
`define EMNAB_WIDTH_HI       5
`define EMNAB_WIDTH_LO       4
`define EMNAB_WP_BIT         3
`define EMNAB_CTRL_MASK      32'h00020F38

// ==========================================================================
// reset values
`define EMNAB_CTRL_RST       32'h00000000
`define EMNAB_RDLY_RST       5'h01
`define EMNAB_RWAIT_RST      5'h03
`define EMNAB_WDLY_RST       5'h01
`define EMNAB_WWAIT_RST      5'h03
`define EMNAB_BWAIT_RST      5'h00

// ==========================================================================
// timing: one bus clock period is two hclk cycles
`define EMNAB_GAP_HALVES     7'h02

`endif

/* core/emnab_pkg.sv */
// types of the external non-multiplexed memory bus controller
`default_nettype none
package emnab_pkg;

    // ======================================================================
    // sequencer states, one-hot
    typedef enum logic [6:0] {
        EMNAB_IDLE = 7'h01,
        EMNAB_CAPT = 7'h02,
        EMNAB_RCYC = 7'h04,
        EMNAB_RGAP = 7'h08,
        EMNAB_PAGE = 7'h10,
        EMNAB_WCYC = 7'h20,
        EMNAB_DONE = 7'h40
    } emnab_state_t;

    // ======================================================================
    // one captured processor access
    typedef struct packed {
        logic        wr;
        logic [1:0]  bank;
        logic [15:0] addr;
        logic [2:0]  nb;
    } emnab_req_t;

    // per-bank strobe timing
    typedef struct packed {
        logic [4:0] rad;
        logic [4:0] rws;
        logic [4:0] wad;
        logic [4:0] wws;
        logic [4:0] bws;
    } emnab_timing_t;

endpackage : emnab_pkg

`default_nettype wire

/* core/emnab_ctrl.sv */
// external 8-bit non-multiplexed asynchronous memory bus controller
//
// Overview of operation
// - read strobe falls read-assert delay after select
// - read strobe low wait minus delay plus one
// - write strobe on falling edges, ends before select
// - write strobe falls delay plus half period
// - write strobe low wait minus delay plus one
// - delay one gives 1.5 setup, 0.5 hold
// - halfword two bytes, word four bytes
// - select stays low across multi-byte writes
// - read bytes assembled before returning
// - page reads burst four, eight, sixteen bytes
// - page read: one normal read, then per-clock
// - strobe and select held through the page
// - burst wait states inserted between page bytes
// - every bank has its own control set
// - bit 17 synchronous write flag, stored only
// - bits 11:10 select burst read length
// - bit 9 synchronous read flag, stored only
// - bit 8 enables page mode reads
// - bits 5:4 bus width field, stored only, bus stays 8-bit
// - bit 3 write-protects the bank
// - all timing derived from internal bus clock
// - sixteen address lines, 64 KB per bank
`include "emnab_params.svh"
`timescale 1ns/1ps
`default_nettype none

module emnab_ctrl
    import emnab_pkg::*;
(
    input  wire logic        hclk,                // bus clock, 200 MHz
    input  wire logic        hresetn,             // async reset, active low
    input  wire logic        hsel,                // slave select
    input  wire logic [31:0] haddr,               // byte address
    input  wire logic [1:0]  htrans,              // transfer type
    input  wire logic        hwrite,              // write access
    input  wire logic [2:0]  hsize,               // access size
    input  wire logic [31:0] hwdata,              // write data
    input  wire logic        hready,              // bus ready
    output logic      [31:0] hrdata,              // read data
    output logic             hreadyout,           // slave ready
    output logic             hresp,               // always okay
    output logic             bus_clk,             // external bus clock
    output logic      [15:0] mem_addr,            // external address
    input  wire logic [7:0]  mem_data_i,          // data pins in
    output logic      [7:0]  mem_data_o,          // data pins out
    output logic             mem_data_oe,         // data pins driven
    output logic      [3:0]  bank_select_n,       // bank chip selects
    output logic             read_strobe_n,       // read strobe
    output logic             byte_write_strobe_n  // write strobe
);

    // ======================================================================
    // timing helpers, in half bus periods (hclk cycles)
    function automatic logic [6:0] f_ron(input logic [4:0] rad,
                                         input logic [4:0] rws);
        logic [4:0] d;
        d = (rad > rws) ? rws : rad;
        return {1'b0, d, 1'b0};
    endfunction : f_ron

    function automatic logic [6:0] f_rend(input logic [4:0] rws);
        return {1'b0, rws, 1'b0} + 7'h02;
    endfunction : f_rend

    function automatic logic [6:0] f_won(input logic [4:0] wad,
                                         input logic [4:0] wws);
        logic [4:0] d;
        d = (wad > wws) ? wws : wad;
        return {1'b0, d, 1'b1};
    endfunction : f_won

    function automatic logic [6:0] f_wend(input logic [4:0] wws);
        return {1'b0, wws, 1'b0} + 7'h04;
    endfunction : f_wend

    function automatic logic [4:0] f_plen(input logic [1:0] sel);
        case (sel)
            2'b01:   return 5'h08;
            2'b10:   return 5'h10;
            default: return 5'h04;
        endcase
    endfunction : f_plen

    // ======================================================================
    // state
    logic [31:0]   ctrl_r [4];
    emnab_timing_t tim_r  [4];
    emnab_state_t  state_r, state_nxt;
    emnab_req_t    req_r;
    logic [6:0]    hc_r, hc_nxt;
    logic [4:0]    idx_r, idx_nxt;
    logic          page_r;
    logic [15:0]   base_r;
    logic [31:0]   wbuf_r, rbuf_r, hrdata_r;
    logic          hsel_buf_r;
    logic          rph_r, rwr_r;
    logic [7:0]    raddr_r;
    logic          bclk_r;
    logic [7:0]    din_s1_r, din_s2_r;
    logic [15:0]   mem_addr_r;
    logic [7:0]    mem_data_r;
    logic          oe_r, rd_n_r, wr_n_r;
    logic [3:0]    cs_n_r;

    logic          accept, is_reg, sample, last, page_ok, wp_hit;
    logic [2:0]    size_nb;
    logic [4:0]    plen;
    logic [6:0]    ron, rend, won, wend, pl;
    logic [15:0]   addr_nxt, cur_addr, off;
    logic [31:0]   reg_rd;
    emnab_timing_t t;
    logic [31:0]   c;
    logic          samp_p1_r, samp_p2_r;
    logic [1:0]    lane_p1_r, lane_p2_r;

    // ======================================================================
    // decode of the current access
    assign accept  = hsel && hready && htrans[1];
    assign is_reg  = haddr[`EMNAB_REG_SPACE_BIT];
    assign size_nb = (hsize == 3'h0) ? 3'h1 : (hsize == 3'h1) ? 3'h2 : 3'h4;
    assign t       = tim_r[req_r.bank];
    assign c       = ctrl_r[req_r.bank];
    assign plen    = f_plen(c[`EMNAB_BURST_READ_LENGTH_HI:`EMNAB_BURST_READ_LENGTH_LO]);
    assign ron     = f_ron(t.rad, t.rws);
    assign rend    = f_rend(t.rws);
    assign won     = f_won(t.wad, t.wws);
    assign wend    = f_wend(t.wws);
    assign pl      = {1'b0, t.bws, 1'b0} + 7'h02;
    assign wp_hit  = req_r.wr && c[`EMNAB_WP_BIT];
    assign off     = req_r.addr & {11'h000, plen - 5'h01};
    assign page_ok = !req_r.wr && c[`EMNAB_PAGE_EN_BIT]
                     && (off + {13'h0000, req_r.nb} <= {11'h000, plen});
    assign cur_addr = (page_r ? base_r : req_r.addr) + {11'h000, idx_r};
    assign last    = page_r ? (idx_r + 5'h01 == plen)
                            : (idx_r + 5'h01 == {2'b00, req_r.nb});
    // only bytes inside the requested span land in the read buffer
    assign sample  = ((state_r == EMNAB_RCYC) && (hc_r == rend - 7'h01)
                      || (state_r == EMNAB_PAGE) && (hc_r == pl - 7'h01))
                     && ((cur_addr - req_r.addr) < {13'h0000, req_r.nb});

    // ======================================================================
    // sequencer next state
    always_comb begin
        state_nxt = state_r;
        hc_nxt    = hc_r + 7'h01;
        idx_nxt   = idx_r;
        case (state_r)
            EMNAB_IDLE, EMNAB_DONE: begin
                state_nxt = (accept && !is_reg) ? EMNAB_CAPT : EMNAB_IDLE;
            end
            EMNAB_CAPT: begin
                hc_nxt  = 7'h00;
                idx_nxt = 5'h00;
                if (wp_hit) begin
                    state_nxt = EMNAB_DONE;
                end else if (!bclk_r) begin
                    // start each byte cycle on a rising bus clock edge
                    state_nxt = req_r.wr ? EMNAB_WCYC : EMNAB_RCYC;
                end
            end
            EMNAB_RCYC: begin
                if (hc_r == rend - 7'h01) begin
                    hc_nxt  = 7'h00;
                    idx_nxt = idx_r + 5'h01;
                    if (page_r) begin
                        state_nxt = EMNAB_PAGE;
                    end else if (last) begin
                        state_nxt = EMNAB_DONE;
                    end else begin
                        state_nxt = EMNAB_RGAP;
                    end
                end
            end
            EMNAB_RGAP: begin
                if (hc_r == `EMNAB_GAP_HALVES - 7'h01) begin
                    hc_nxt    = 7'h00;
                    state_nxt = EMNAB_RCYC;
                end
            end
            EMNAB_PAGE: begin
                if (hc_r == pl - 7'h01) begin
                    hc_nxt  = 7'h00;
                    idx_nxt = idx_r + 5'h01;
                    if (last) begin
                        state_nxt = EMNAB_DONE;
                    end
                end
            end
            EMNAB_WCYC: begin
                if (hc_r == wend - 7'h01) begin
                    hc_nxt  = 7'h00;
                    idx_nxt = idx_r + 5'h01;
                    if (last) begin
                        state_nxt = EMNAB_DONE;
                    end
                end
            end
            default: begin
                state_nxt = EMNAB_IDLE;
            end
        endcase
    end

    assign addr_nxt = (page_r ? base_r : req_r.addr) + {11'h000, idx_nxt};

    // sequencer registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= EMNAB_IDLE;
            hc_r    <= 7'h00;
            idx_r   <= 5'h00;
        end else begin
            state_r <= state_nxt;
            hc_r    <= hc_nxt;
            idx_r   <= idx_nxt;
        end
    end

    // free-running bus clock, half the hclk rate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bclk_r <= 1'b0;
        end else begin
            bclk_r <= !bclk_r;
        end
    end

    // data pins pass two flip-flops before use
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            din_s1_r <= 8'h00;
            din_s2_r <= 8'h00;
        end else begin
            din_s1_r <= mem_data_i;
            din_s2_r <= din_s1_r;
        end
    end

    // request capture and write data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_r  <= '0;
            wbuf_r <= 32'h00000000;
            page_r <= 1'b0;
            base_r <= 16'h0000;
        end else begin
            if ((state_r == EMNAB_IDLE || state_r == EMNAB_DONE)
                && accept && !is_reg) begin
                req_r.wr   <= hwrite;
                req_r.bank <= haddr[`EMNAB_BANK_BIT_HI:`EMNAB_BANK_BIT_LO];
                req_r.addr <= haddr[15:0];
                req_r.nb   <= size_nb;
            end
            if (state_r == EMNAB_CAPT) begin
                wbuf_r <= hwdata;
                page_r <= page_ok;
                base_r <= req_r.addr - off;
            end
        end
    end

    // pins reach din_s2_r two cycles late, so strobe and lane follow them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            samp_p1_r <= 1'b0;
            samp_p2_r <= 1'b0;
            lane_p1_r <= 2'b00;
            lane_p2_r <= 2'b00;
        end else begin
            samp_p1_r <= sample;
            samp_p2_r <= samp_p1_r;
            lane_p1_r <= cur_addr[1:0];
            lane_p2_r <= lane_p1_r;
        end
    end

    // read buffer collects bytes on their lanes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rbuf_r <= 32'h00000000;
        end else if (state_r == EMNAB_CAPT) begin
            rbuf_r <= 32'h00000000;
        end else if (samp_p2_r) begin
            rbuf_r[lane_p2_r*8 +: 8] <= din_s2_r;
        end
    end

    // ======================================================================
    // external pins, registered from next state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cs_n_r     <= 4'hF;
            rd_n_r     <= 1'b1;
            wr_n_r     <= 1'b1;
            oe_r       <= 1'b0;
            mem_addr_r <= 16'h0000;
            mem_data_r <= 8'h00;
        end else begin
            // select held across all bytes of a write or page
            cs_n_r <= (state_nxt == EMNAB_RCYC || state_nxt == EMNAB_PAGE
                       || state_nxt == EMNAB_WCYC)
                      ? ~(4'h1 << req_r.bank) : 4'hF;
            rd_n_r <= !((state_nxt == EMNAB_RCYC && hc_nxt >= ron)
                        || state_nxt == EMNAB_PAGE);
            // odd half counts fall on falling bus clock edges
            wr_n_r <= !(state_nxt == EMNAB_WCYC && hc_nxt >= won
                        && hc_nxt < wend - 7'h01);
            oe_r   <= (state_nxt == EMNAB_WCYC);
            if (state_nxt == EMNAB_RCYC || state_nxt == EMNAB_PAGE
                || state_nxt == EMNAB_WCYC) begin
                mem_addr_r <= addr_nxt;
                mem_data_r <= wbuf_r[addr_nxt[1:0]*8 +: 8];
            end
        end
    end

    assign bank_select_n       = cs_n_r;
    assign read_strobe_n       = rd_n_r;
    assign byte_write_strobe_n = wr_n_r;
    assign mem_data_oe         = oe_r;
    assign mem_addr            = mem_addr_r;
    assign mem_data_o          = mem_data_r;
    assign bus_clk             = bclk_r;

    // ======================================================================
    // register read mux
    always_comb begin
        reg_rd = 32'h00000000;
        if (haddr[7:0] == `EMNAB_OFF_STATUS) begin
            reg_rd = {24'h000000, state_r, state_r != EMNAB_IDLE};
        end else if (!haddr[7]) begin
            case (haddr[4:0])
                `EMNAB_OFF_CTRL:  reg_rd = ctrl_r[haddr[6:5]];
                `EMNAB_OFF_RDLY:  reg_rd = {27'h0, tim_r[haddr[6:5]].rad};
                `EMNAB_OFF_RWAIT: reg_rd = {27'h0, tim_r[haddr[6:5]].rws};
                `EMNAB_OFF_WDLY:  reg_rd = {27'h0, tim_r[haddr[6:5]].wad};
                `EMNAB_OFF_WWAIT: reg_rd = {27'h0, tim_r[haddr[6:5]].wws};
                `EMNAB_OFF_BWAIT: reg_rd = {27'h0, tim_r[haddr[6:5]].bws};
                default:          reg_rd = 32'h00000000;
            endcase
        end
    end

    // register access phase tracking and read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rph_r      <= 1'b0;
            rwr_r      <= 1'b0;
            raddr_r    <= 8'h00;
            hrdata_r   <= 32'h00000000;
            hsel_buf_r <= 1'b0;
        end else begin
            rph_r <= accept && is_reg;
            if (accept && is_reg) begin
                rwr_r      <= hwrite;
                raddr_r    <= haddr[7:0];
                hrdata_r   <= reg_rd;
                hsel_buf_r <= 1'b0;
            end else if (state_nxt == EMNAB_DONE && !req_r.wr) begin
                hsel_buf_r <= 1'b1;
            end
        end
    end

    // per-bank control and timing registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int b = 0; b < 4; b++) begin
                ctrl_r[b]    <= `EMNAB_CTRL_RST;
                tim_r[b].rad <= `EMNAB_RDLY_RST;
                tim_r[b].rws <= `EMNAB_RWAIT_RST;
                tim_r[b].wad <= `EMNAB_WDLY_RST;
                tim_r[b].wws <= `EMNAB_WWAIT_RST;
                tim_r[b].bws <= `EMNAB_BWAIT_RST;
            end
        end else if (rph_r && rwr_r && !raddr_r[7]) begin
            case (raddr_r[4:0])
                // sync and width bits are stored for software only
                `EMNAB_OFF_CTRL:  ctrl_r[raddr_r[6:5]] <=
                                  hwdata & `EMNAB_CTRL_MASK;
                `EMNAB_OFF_RDLY:  tim_r[raddr_r[6:5]].rad <= hwdata[4:0];
                `EMNAB_OFF_RWAIT: tim_r[raddr_r[6:5]].rws <= hwdata[4:0];
                `EMNAB_OFF_WDLY:  tim_r[raddr_r[6:5]].wad <= hwdata[4:0];
                `EMNAB_OFF_WWAIT: tim_r[raddr_r[6:5]].wws <= hwdata[4:0];
                `EMNAB_OFF_BWAIT: tim_r[raddr_r[6:5]].bws <= hwdata[4:0];
                default: ;
            endcase
        end
    end

    assign hrdata    = hsel_buf_r ? rbuf_r : hrdata_r;
    // ready waits until the last synchronised byte has landed
    assign hreadyout = ((state_r == EMNAB_IDLE) || (state_r == EMNAB_DONE))
                       && !samp_p1_r && !samp_p2_r;
    assign hresp     = 1'b0;

    // ======================================================================
    // checks
    logic [6:0] rlow_cnt_r, wlow_cnt_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rlow_cnt_r <= 7'h00;
            wlow_cnt_r <= 7'h00;
        end else begin
            rlow_cnt_r <= rd_n_r ? 7'h00 : rlow_cnt_r + 7'h01;
            wlow_cnt_r <= wr_n_r ? 7'h00 : wlow_cnt_r + 7'h01;
        end
    end

    a_rd_delay_low: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_r == EMNAB_RCYC) |-> (read_strobe_n == (hc_r < ron)))
        else $error("read strobe not low at programmed delay");

    a_rd_width: assert property (@(posedge hclk) disable iff (!hresetn)
        ($rose(read_strobe_n) && !page_r) |-> (rlow_cnt_r == rend - ron))
        else $error("read strobe width wrong");

    a_wr_fall_edge: assert property (@(posedge hclk) disable iff (!hresetn)
        $changed(byte_write_strobe_n) |-> !bus_clk)
        else $error("write strobe moved off falling bus clock edge");

    a_wr_assert_pos: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(byte_write_strobe_n) |-> (hc_r == won))
        else $error("write strobe fell at wrong position");

    a_wr_width: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(byte_write_strobe_n) |-> (wlow_cnt_r == wend - 7'h01 - won))
        else $error("write strobe width wrong");

    a_wr_cs_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        ($rose(byte_write_strobe_n) && last) |=> (bank_select_n == 4'hF))
        else $error("select not released half period after write");

    a_cs_keep_wr: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_r == EMNAB_WCYC && $past(state_r) == EMNAB_WCYC)
        |-> (bank_select_n != 4'hF))
        else $error("select released inside a multi-byte write");

    a_page_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_r == EMNAB_PAGE) |-> (!read_strobe_n
                                     && bank_select_n != 4'hF))
        else $error("strobe or select dropped during page read");

    a_wp_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_r == EMNAB_CAPT && wp_hit) |=> ##[0:1]
        (state_r == EMNAB_DONE && byte_write_strobe_n
         && bank_select_n == 4'hF))
        else $error("protected write reached the bus");

    a_byte_split: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_r == EMNAB_WCYC && state_nxt == EMNAB_DONE)
        |-> (idx_r + 5'h01 == {2'b00, req_r.nb}))
        else $error("wrong number of byte cycles");

    c_word_write: cover property (@(posedge hclk) disable iff (!hresetn)
        state_r == EMNAB_WCYC && req_r.nb == 3'h4 && state_nxt == EMNAB_DONE);
    c_half_read: cover property (@(posedge hclk) disable iff (!hresetn)
        state_r == EMNAB_RGAP && req_r.nb == 3'h2);
    c_page_read: cover property (@(posedge hclk) disable iff (!hresetn)
        state_r == EMNAB_PAGE && state_nxt == EMNAB_DONE);
    c_wp_write: cover property (@(posedge hclk) disable iff (!hresetn)
        state_r == EMNAB_CAPT && wp_hit);

endmodule : emnab_ctrl

`default_nettype wire

/* testbench/emnab_sram_model.sv */
// behavioural byte-wide asynchronous memory on the far side
`timescale 1ns/1ps
`default_nettype none
module emnab_sram_model (
    input  wire logic        cs_n, // any bank selected, active low
    input  wire logic        rd_n, // read strobe, active low
    input  wire logic        wr_n, // write strobe, active low
    input  wire logic [15:0] addr, // address pins
    input  wire logic [7:0]  din,  // data from controller
    output logic      [7:0]  dout  // data to controller
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_r = 8'h00;
    // store the byte as the write strobe rises
    always @(posedge wr_n) if (!cs_n) mem[addr] = din;
    // remember the last byte driven, so a released bus shows its inverse
    always @(posedge rd_n) last_r = mem[addr];
    // answer at once while read, never hold stale data after release
    assign dout = (!cs_n && !rd_n) ? mem[addr] : ~last_r;
endmodule : emnab_sram_model
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the external memory bus controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct { logic w; logic [31:0] a, d, e; } emnab_row_t;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, rd_n, wr_n, csp;
    logic        oe, resp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] maddr;
    logic [7:0]  mdi, mdo;
    logic [3:0]  cs_n;
    int fails, total_checks, n, csl, rlead, wlead, rdw, rdlast, wrw, wrlast;
    int csr, c0, oebad;
    emnab_row_t rows[12] = '{'{0, 32'h100040, 0, 0}, '{0, 32'h100044, 0, 1},
        '{0, 32'h100048, 0, 3}, '{0, 32'h10004C, 0, 1},
        '{0, 32'h100050, 0, 3}, '{0, 32'h100054, 0, 0},
        '{1, 32'h100060, 32'hFFFFFFFF, 32'h00020F38}, '{1, 32'h100004, 0, 0},
        '{1, 32'h100008, 2, 2}, '{1, 32'h100010, 2, 2},
        '{1, 32'h100020, 8, 8}, '{1, 32'h1000FC, 5, 0}};
    emnab_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(resp), .bus_clk(), .mem_addr(maddr),
        .mem_data_i(mdi), .mem_data_o(mdo), .mem_data_oe(oe),
        .bank_select_n(cs_n), .read_strobe_n(rd_n),
        .byte_write_strobe_n(wr_n));
    emnab_sram_model mem (.cs_n(&cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .addr(maddr), .din(mdo), .dout(mdi));
    // free running 200 MHz clock
    initial begin
        hclk = 1'h0;
        forever #2.5 hclk = ~hclk;
    end
    // measure strobe leads, widths and select cycles on settled pins
    always @(negedge hclk) begin
        csl = &cs_n ? 0 : csl + 1;
        if (!rd_n && rdw == 0) rlead = csl - 1;
        if (!wr_n && wrw == 0) wlead = csl - 1;
        if (!rd_n) rdw++;
        else if (rdw > 0) rdlast = rdw;
        if (rd_n) rdw = 0;
        if (!wr_n) wrw++;
        else if (wrw > 0) wrlast = wrw;
        if (wr_n) wrw = 0;
        if (!(&cs_n) && csp) csr++;
        csp = &cs_n;
        if (!wr_n && !oe) oebad++;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    task automatic chk(string what, logic [31:0] got, logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // wait, bounded, for ready seen high at a rising edge
    task automatic wait_ready();
        n = 0;
        do @(negedge hclk); while (hreadyout !== 1'h1 && ++n < 4000);
        rd = hrdata;
        if (n >= 4000) begin
            fails++;
            final_report();
        end
        @(posedge hclk);
    endtask : wait_ready
    task automatic xfer(logic w, logic [31:0] a, logic [2:0] sz,
                        logic [31:0] wd);
        hsel <= 1'h1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= sz;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
    endtask : xfer
    task automatic op(logic w, logic [31:0] a, logic [2:0] sz,
                      logic [31:0] wd, logic [31:0] m, logic [31:0] e, int k);
        c0 = csr;
        xfer(w, a, sz, wd);
        chk("data", rd & m, e);
        chk("selects", csr - c0, k);
        chk("response", resp, 0);
    endtask : op
    // main sequence
    initial begin
        {hresetn, hsel, haddr, htrans, hwrite, hsize, hwdata, csp} = 1'h1;
        hresetn = 1'h0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'h1;
        foreach (rows[i]) begin
            if (rows[i].w) xfer(1'h1, rows[i].a, 3'h2, rows[i].d);
            xfer(1'h0, rows[i].a, 3'h2, 32'h0);
            chk("register", rd, rows[i].e);
        end
        $display("register rows done");
        op(1'h1, 32'h20, 3'h0, 32'h5A, 0, 0, 1);
        chk("write lead", wlead, 3);
        chk("write width", wrlast, 4);
        op(1'h1, 32'h10, 3'h2, 32'hA5C31E77, 0, 0, 1);
        op(1'h0, 32'h10, 3'h2, 0, 32'hFFFFFFFF, 32'hA5C31E77, 4);
        chk("read lead", rlead, 0);
        chk("read width", rdlast, 6);
        op(1'h0, 32'h12, 3'h1, 0, 32'hFFFF0000, 32'hA5C30000, 2);
        op(1'h1, 32'h10005, 3'h0, 32'hAA00, 0, 0, 0);
        xfer(1'h1, 32'h100020, 3'h2, 32'h100);
        op(1'h1, 32'h10020, 3'h2, 32'h44332211, 0, 0, 1);
        op(1'h0, 32'h10020, 3'h2, 0, 32'hFFFFFFFF, 32'h44332211, 1);
        chk("page width", rdlast, 12);
        xfer(1'h1, 32'h100020, 3'h2, 32'h500);
        op(1'h0, 32'h10020, 3'h2, 0, 32'hFFFFFFFF, 32'h44332211, 1);
        chk("page8 width", rdlast, 20);
        chk("data drive", oebad, 0);
        $display("memory tests done");
        hresetn <= 1'h0;
        repeat (12) @(posedge hclk);
        chk("ready in reset", hreadyout, 1);
        hresetn <= 1'h1;
        xfer(1'h0, 32'h100008, 3'h2, 0);
        chk("wait after reset", rd, 3);
        $display("reset test done");
        final_report();
    end
endmodule : tb
`default_nettype wire
